// *** hw/key_scope_defines.svh ***
// Command codes, field limits and reset values for the scope and status interpreter
`ifndef KEY_SCOPE_DEFINES_SVH
`define KEY_SCOPE_DEFINES_SVH
`define CMD_KEY_SCOPE  8'h73
`define CMD_ALL_SCOPE  8'h53
`define CMD_ROW_SCOPE  8'h78
`define CMD_COL_SCOPE  8'h79
`define CMD_SIGNAL     8'h30
`define CMD_DELTA      8'h31
`define CMD_REFERENCE  8'h32
`define CMD_LADDER     8'h33
`define CMD_CANCEL     8'h34
`define CMD_INTEG      8'h35
`define CMD_CHECKSUM   8'h36
`define CMD_STATUS     8'h37
`define KEY_NUM_MAX    8'h3f
`define ROW_COL_MAX    8'h07
`define KEY_RESET      6'h00
`define INDEX_RESET    3'h0
`define BYTE_ZERO      8'h00
`define KEY_STEP       6'h01
`define CANCEL_PAD     6'h00
`define STATUS_PAD     3'h0
`define SUM_RESET      8'h00
`endif

// *** hw/key_scope_pkg.sv ***
// Types shared by the scope and status interpreter
package key_scope_pkg;
   typedef enum logic [1:0] {SCOPE_ALL = 2'h0, SCOPE_ROW = 2'h1, SCOPE_COL = 2'h2} scope_mode_t;
   typedef struct packed {
      logic [2:0] col;
      logic [2:0] row;
   } key_sel_t;
   typedef struct packed {
      logic [7:0] signal;
      logic [7:0] reference;
      logic [7:0] ladderOffset;
      logic [1:0] cancelCapState;
      logic [7:0] integ;
   } key_info_t;
   typedef struct packed {
      logic eeMismatch;
      logic syncFail;
      logic keyError;
      logic keyRecal;
      logic keyDetect;
   } stat_flags_t;
   typedef enum logic [1:0] {CMD_IDLE = 2'b00, CMD_ARG = 2'b01} cmd_state_t;
   typedef enum logic [1:0] {SUM_READ = 2'b00, SUM_LAST = 2'b01, SUM_DONE = 2'b11} sum_state_t;
endpackage

// *** hw/key_scope_status_commands.sv ***
// Scope and status command interpreter for the touch-key matrix
//
// How it works
// - Group scope persists for later commands until another scope command arrives.
// - Reset sets group scope to the whole key matrix.
// - Single-key queries use the key selection; all-keys scope leaves it alone.
// - Row or column command overwrites that coordinate, keeps the other.
// - Key number is row plus eight times column.
// - Keys are acquired in ascending key-number order.
// - Code 0x73 plus key 0..63 selects that key and echoes 0x73.
// - Code 0x53 sets all-keys scope and echoes 0x53.
// - Code 0x78 plus row 0..7 scopes to that row, echoes 0x78.
// - Code 0x79 plus column 0..7 scopes to that column, echoes 0x79.
// - Status commands answer in either direction mode.
// - Code 0x30 returns the selected key's signal level.
// - Code 0x31 returns reference minus signal, clamped at zero.
// - Code 0x32 returns the selected key's reference.
// - Code 0x33 returns the selected key's ladder offset.
// - Code 0x34 returns cancellation capacitor state 0..2.
// - Code 0x35 returns the selected key's detect integrator count.
// - Code 0x36 returns an 8-bit end-around-carry checksum of the eeprom.
// - Checksum is valid only after a reset following setup changes.
// - Checksum is a read-only query in any direction mode.
// - Code 0x37 returns a status byte between 0x00 and 0x1f.
// - Status byte holds five flags in bits 0..4, upper bits zero.
// - Data-returning commands send data only, no command echo.
// - Unknown codes are ignored; host waits completion plus 1ms.
`timescale 1ns/1ns
`include "key_scope_defines.svh"
module key_scope_status_commands #(
   parameter int EE_ADDR_W = 8
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   // Command bytes from the serial port
   input  wire logic                      cmdValid,
   input  wire logic [7:0]                cmdByte,
   // Response bytes to the serial port
   output logic                           rspValid,
   output logic [7:0]                     rspByte,
   // Scope state
   output key_scope_pkg::key_sel_t        selKey,
   output key_scope_pkg::scope_mode_t     scopeMode,
   output logic [2:0]                     scopeIndex,
   // Sensing core data for the selected key
   input  wire key_scope_pkg::key_info_t  keyInfo,
   input  wire key_scope_pkg::stat_flags_t statFlags,
   // Eeprom read port, data one cycle after address
   output logic [EE_ADDR_W-1:0]           eeAddr,
   input  wire logic [7:0]                eeData,
   output logic                           checksumValid,
   // Acquisition sequencing
   input  wire logic                      acqStep,
   output logic [5:0]                     acqKey
);

   if (EE_ADDR_W < 1 || EE_ADDR_W > 16)
   begin : g_check
      $error("EE_ADDR_W must lie in 1..16");
   end

   key_scope_pkg::cmd_state_t state;
   key_scope_pkg::sum_state_t sumState;
   logic [7:0]                pendCode;
   logic [7:0]                checksum;
   logic [8:0]                next_sum;
   logic                      readPend;
   logic                      takeIdle;
   logic                      takeArg;
   logic                      known;
   logic [7:0]                delta;

   assign takeIdle = cmdValid && (state == key_scope_pkg::CMD_IDLE);
   assign takeArg  = cmdValid && (state == key_scope_pkg::CMD_ARG);
   assign known    = (cmdByte == `CMD_ALL_SCOPE) ||
                     ((cmdByte >= `CMD_SIGNAL) && (cmdByte <= `CMD_STATUS));
   assign delta    = (keyInfo.reference > keyInfo.signal) ?
                     (keyInfo.reference - keyInfo.signal) : `BYTE_ZERO;
   assign next_sum = {1'b0, checksum} + {1'b0, eeData};

   // Two-byte command sequencing
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state    <= key_scope_pkg::CMD_IDLE;
         pendCode <= `BYTE_ZERO;
      end
      else
      begin
         case (state)
            key_scope_pkg::CMD_IDLE:
            begin
               if (cmdValid && ((cmdByte == `CMD_KEY_SCOPE) || (cmdByte == `CMD_ROW_SCOPE) ||
                                (cmdByte == `CMD_COL_SCOPE)))
               begin
                  state    <= key_scope_pkg::CMD_ARG;
                  pendCode <= cmdByte;
               end
            end
            default:
            begin
               if (cmdValid)
               begin
                  state <= key_scope_pkg::CMD_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scopeMode  <= key_scope_pkg::SCOPE_ALL;
         scopeIndex <= `INDEX_RESET;
         selKey     <= `KEY_RESET;
      end
      else if (takeIdle && (cmdByte == `CMD_ALL_SCOPE))
      begin
         scopeMode <= key_scope_pkg::SCOPE_ALL;
      end
      else if (takeArg)
      begin
         // specific key, key number is col:row
         if ((pendCode == `CMD_KEY_SCOPE) && (cmdByte <= `KEY_NUM_MAX))
         begin
            selKey <= cmdByte[5:0];
         end
         // row scope also moves the selected row
         else if ((pendCode == `CMD_ROW_SCOPE) && (cmdByte <= `ROW_COL_MAX))
         begin
            scopeMode  <= key_scope_pkg::SCOPE_ROW;
            scopeIndex <= cmdByte[2:0];
            selKey.row <= cmdByte[2:0];
         end
         // column scope also moves the selected column
         else if ((pendCode == `CMD_COL_SCOPE) && (cmdByte <= `ROW_COL_MAX))
         begin
            scopeMode  <= key_scope_pkg::SCOPE_COL;
            scopeIndex <= cmdByte[2:0];
            selKey.col <= cmdByte[2:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rspValid <= 1'b0;
         rspByte  <= `BYTE_ZERO;
      end
      else
      begin
         rspValid <= 1'b0;
         if (takeArg)
         begin
            if (((pendCode == `CMD_KEY_SCOPE) && (cmdByte <= `KEY_NUM_MAX)) ||
                ((pendCode != `CMD_KEY_SCOPE) && (cmdByte <= `ROW_COL_MAX)))
            begin
               rspValid <= 1'b1;
               rspByte  <= pendCode;
            end
         end
         else if (takeIdle && known)
         begin
            rspValid <= 1'b1;
            case (cmdByte)
               `CMD_SIGNAL:    rspByte <= keyInfo.signal;
               `CMD_DELTA:     rspByte <= delta;
               `CMD_REFERENCE: rspByte <= keyInfo.reference;
               `CMD_LADDER:    rspByte <= keyInfo.ladderOffset;
               `CMD_CANCEL:    rspByte <= {`CANCEL_PAD, keyInfo.cancelCapState};
               `CMD_INTEG:     rspByte <= keyInfo.integ;
               `CMD_CHECKSUM:  rspByte <= checksum;
               `CMD_STATUS:    rspByte <= {`STATUS_PAD, statFlags};
               default:        rspByte <= cmdByte;
            endcase
         end
      end
   end

   // checksum built once after each reset
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sumState      <= key_scope_pkg::SUM_READ;
         eeAddr        <= '0;
         readPend      <= 1'b0;
         checksumValid <= 1'b0;
      end
      else
      begin
         readPend <= (sumState == key_scope_pkg::SUM_READ);
         case (sumState)
            key_scope_pkg::SUM_READ:
            begin
               if (eeAddr == {EE_ADDR_W{1'b1}})
               begin
                  sumState <= key_scope_pkg::SUM_LAST;
               end
               else
               begin
                  eeAddr <= eeAddr + 1'b1;
               end
            end
            key_scope_pkg::SUM_LAST:
            begin
               sumState      <= key_scope_pkg::SUM_DONE;
               checksumValid <= 1'b1;
            end
            default:
            begin
               sumState <= key_scope_pkg::SUM_DONE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         checksum <= `SUM_RESET;
      end
      else if (readPend)
      begin
         checksum <= next_sum[7:0] + {7'h00, next_sum[8]};
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acqKey <= `KEY_RESET;
      end
      else if (acqStep)
      begin
         acqKey <= acqKey + `KEY_STEP;
      end
   end

   a_reset_scope: assert property (@(posedge clk) $rose(rst_n) |->
      scopeMode == key_scope_pkg::SCOPE_ALL)
      else $error("scope not all keys after reset");

   a_all_echo: assert property (@(posedge clk) disable iff (!rst_n)
      takeIdle && (cmdByte == `CMD_ALL_SCOPE) |=>
      rspValid && (rspByte == `CMD_ALL_SCOPE) && (scopeMode == key_scope_pkg::SCOPE_ALL))
      else $error("all-keys scope not applied or echoed");

   a_all_keeps_key: assert property (@(posedge clk) disable iff (!rst_n)
      takeIdle && (cmdByte == `CMD_ALL_SCOPE) |=> $stable(selKey))
      else $error("all-keys scope changed the selected key");

   a_key_select: assert property (@(posedge clk) disable iff (!rst_n)
      takeArg && (pendCode == `CMD_KEY_SCOPE) && (cmdByte <= `KEY_NUM_MAX) |=>
      (selKey == $past(cmdByte[5:0])) && rspValid && (rspByte == `CMD_KEY_SCOPE))
      else $error("specific key not selected or echoed");

   a_row_keeps_col: assert property (@(posedge clk) disable iff (!rst_n)
      takeArg && (pendCode == `CMD_ROW_SCOPE) && (cmdByte <= `ROW_COL_MAX) |=>
      (selKey.col == $past(selKey.col)) && (selKey.row == $past(cmdByte[2:0])) &&
      (scopeMode == key_scope_pkg::SCOPE_ROW))
      else $error("row scope handled wrongly");

   a_scope_persists: assert property (@(posedge clk) disable iff (!rst_n)
      !cmdValid |=> $stable(scopeMode) && $stable(scopeIndex) && $stable(selKey))
      else $error("scope changed without a command");

   a_delta_clamp: assert property (@(posedge clk) disable iff (!rst_n)
      takeIdle && (cmdByte == `CMD_DELTA) && (keyInfo.signal >= keyInfo.reference) |=>
      rspValid && (rspByte == `BYTE_ZERO))
      else $error("delta not clamped to zero");

   a_status_byte: assert property (@(posedge clk) disable iff (!rst_n)
      takeIdle && (cmdByte == `CMD_STATUS) |=>
      (rspByte[7:5] == `STATUS_PAD) && (rspByte[4:0] == $past(statFlags)))
      else $error("status byte malformed");

   a_unknown_silent: assert property (@(posedge clk) disable iff (!rst_n)
      takeIdle && !known && (cmdByte != `CMD_KEY_SCOPE) && (cmdByte != `CMD_ROW_SCOPE) &&
      (cmdByte != `CMD_COL_SCOPE) |=> !rspValid ##1 (!rspValid || $past(cmdValid)))
      else $error("unknown code answered");

   a_acq_order: assert property (@(posedge clk) disable iff (!rst_n)
      acqStep |=> acqKey == ($past(acqKey) + `KEY_STEP))
      else $error("acquisition order broken");

   a_col_keeps_row: assert property (@(posedge clk) disable iff (!rst_n)
      takeArg && (pendCode == `CMD_COL_SCOPE) && (cmdByte <= `ROW_COL_MAX) |=>
      (selKey.row == $past(selKey.row)) && (selKey.col == $past(cmdByte[2:0])) &&
      (scopeMode == key_scope_pkg::SCOPE_COL) && (scopeIndex == $past(cmdByte[2:0])))
      else $error("column scope handled wrongly");

   a_range_refused: assert property (@(posedge clk) disable iff (!rst_n)
      takeArg && (((pendCode == `CMD_KEY_SCOPE) && (cmdByte > `KEY_NUM_MAX)) ||
      ((pendCode != `CMD_KEY_SCOPE) && (cmdByte > `ROW_COL_MAX))) |=>
      !rspValid && $stable(selKey) && $stable(scopeMode))
      else $error("out-of-range argument accepted");

   a_signal_answer: assert property (@(posedge clk) disable iff (!rst_n)
      takeIdle && (cmdByte == `CMD_SIGNAL) |=>
      rspValid && (rspByte == $past(keyInfo.signal)))
      else $error("signal level answer wrong");

   a_delta_value: assert property (@(posedge clk) disable iff (!rst_n)
      takeIdle && (cmdByte == `CMD_DELTA) && (keyInfo.reference > keyInfo.signal) |=>
      rspValid && (rspByte == ($past(keyInfo.reference) - $past(keyInfo.signal))))
      else $error("delta value wrong");

   a_cancel_answer: assert property (@(posedge clk) disable iff (!rst_n)
      takeIdle && (cmdByte == `CMD_CANCEL) |=>
      rspValid && (rspByte == {`CANCEL_PAD, $past(keyInfo.cancelCapState)}))
      else $error("cancellation state answer wrong");

   a_integ_answer: assert property (@(posedge clk) disable iff (!rst_n)
      takeIdle && (cmdByte == `CMD_INTEG) |=>
      rspValid && (rspByte == $past(keyInfo.integ)))
      else $error("integrator count answer wrong");

   a_checksum_hold: assert property (@(posedge clk) disable iff (!rst_n)
      checksumValid |=> checksumValid && $stable(checksum))
      else $error("checksum changed after scan");

endmodule

// *** sim/key_eeprom_model.sv ***
// Eeprom contents model answering one cycle after the address
`timescale 1ns/1ns
module key_eeprom_model #(
   parameter int EE_ADDR_W = 4
) (
   // Clock
   input  wire logic                 clk,
   // Read port
   input  wire logic [EE_ADDR_W-1:0] eeAddr,
   output logic [7:0]                eeData
);
   always_ff @(posedge clk)
   begin
      eeData <= 8'(eeAddr) * 8'h1d + 8'h35;
   end
endmodule

// *** sim/test_key_scope_status_commands.sv ***
// Self-checking bench for the scope and status interpreter
`timescale 1ns/1ns
module test_key_scope_status_commands;
   localparam int EE_ADDR_W = 4;
   logic                       clk;
   logic                       rst_n;
   logic                       cmdValid;
   logic [7:0]                 cmdByte;
   logic                       rspValid;
   logic [7:0]                 rspByte;
   key_scope_pkg::key_sel_t    selKey;
   key_scope_pkg::scope_mode_t scopeMode;
   logic [2:0]                 scopeIndex;
   key_scope_pkg::key_info_t   keyInfo;
   key_scope_pkg::stat_flags_t statFlags;
   logic [EE_ADDR_W-1:0]       eeAddr;
   logic [7:0]                 eeData;
   logic                       checksumValid;
   logic                       acqStep;
   logic [5:0]                 acqKey;
   int                         error_cnt;
   int                         samples_checked;

   key_scope_status_commands #(.EE_ADDR_W(EE_ADDR_W)) dut_u (
      .clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdByte(cmdByte),
      .rspValid(rspValid), .rspByte(rspByte), .selKey(selKey), .scopeMode(scopeMode),
      .scopeIndex(scopeIndex), .keyInfo(keyInfo), .statFlags(statFlags),
      .eeAddr(eeAddr), .eeData(eeData), .checksumValid(checksumValid),
      .acqStep(acqStep), .acqKey(acqKey));

   key_eeprom_model #(.EE_ADDR_W(EE_ADDR_W)) ee_u (
      .clk(clk), .eeAddr(eeAddr), .eeData(eeData));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Sends one or two bytes, then judges the answer one cycle on
   task automatic cmd(input logic [7:0] b1, input logic two, input logic [7:0] b2,
                      input logic ans, input logic [7:0] exp);
      @(posedge clk);
      cmdValid <= 1'b1;
      cmdByte  <= b1;
      @(posedge clk);
      if (two)
      begin
         cmdByte <= b2;
         @(posedge clk);
      end
      cmdValid <= 1'b0;
      #1;
      check({7'h0, rspValid}, {7'h0, ans});
      if (ans)
         check(rspByte, exp);
   endtask

   task automatic scope(input logic [1:0] m, input logic [5:0] k);
      check({6'h0, scopeMode}, {6'h0, m});
      check({2'h0, selKey}, {2'h0, k});
   endtask

   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      scope(key_scope_pkg::SCOPE_ALL, 6'h00);
      check({4'h0, eeAddr}, 8'h00);
      check({7'h0, checksumValid}, 8'h00);
      check({2'h0, acqKey}, 8'h00);
      @(posedge clk);
      rst_n <= 1'b1;
   endtask

   task automatic t_scope();
      cmd(8'h73, 1'b1, 8'h09, 1'b1, 8'h73);
      check({2'h0, selKey}, 8'h09);
      cmd(8'h53, 1'b0, 8'h00, 1'b1, 8'h53);
      scope(key_scope_pkg::SCOPE_ALL, 6'h09);
      cmd(8'h78, 1'b1, 8'h02, 1'b1, 8'h78);
      scope(key_scope_pkg::SCOPE_ROW, 6'h0a);
      check({5'h0, scopeIndex}, 8'h02);
      cmd(8'h79, 1'b1, 8'h03, 1'b1, 8'h79);
      scope(key_scope_pkg::SCOPE_COL, 6'h1a);
      check({5'h0, scopeIndex}, 8'h03);
      cmd(8'h78, 1'b1, 8'h08, 1'b0, 8'h00);
      cmd(8'h73, 1'b1, 8'h40, 1'b0, 8'h00);
      cmd(8'h41, 1'b0, 8'h00, 1'b0, 8'h00);
      scope(key_scope_pkg::SCOPE_COL, 6'h1a);
   endtask

   task automatic t_status();
      logic [7:0] exp [6];
      exp = '{8'h90, 8'h00, 8'h70, 8'h5a, 8'h02, 8'h0c};
      @(posedge clk);
      keyInfo <= '{signal: 8'h90, reference: 8'h70, ladderOffset: 8'h5a,
                   cancelCapState: 2'h2, integ: 8'h0c};
      for (int i = 0; i < 6; i++)
         cmd(8'h30 + 8'(i), 1'b0, 8'h00, 1'b1, exp[i]);
      @(posedge clk);
      keyInfo.signal <= 8'h50;
      cmd(8'h31, 1'b0, 8'h00, 1'b1, 8'h20);
      @(posedge clk);
      statFlags <= 5'h15;
      cmd(8'h37, 1'b0, 8'h00, 1'b1, 8'h15);
      @(posedge clk);
      statFlags <= 5'h1f;
      cmd(8'h37, 1'b0, 8'h00, 1'b1, 8'h1f);
   endtask

   task automatic t_acq();
      @(posedge clk);
      acqStep <= 1'b1;
      @(posedge clk);
      acqStep <= 1'b0;
      #1;
      check({2'h0, acqKey}, 8'h01);
      @(posedge clk);
      acqStep <= 1'b1;
      repeat (63) @(posedge clk);
      acqStep <= 1'b0;
      #1;
      check({2'h0, acqKey}, 8'h00);
   endtask

   task automatic t_checksum();
      logic [8:0] t;
      logic [7:0] s;
      int         n;
      s = 8'h00;
      for (int a = 0; a < 2 ** EE_ADDR_W; a++)
      begin
         t = {1'b0, s} + {1'b0, 8'(a) * 8'h1d + 8'h35};
         s = t[7:0] + {7'h0, t[8]};
      end
      n = 0;
      while (checksumValid !== 1'b1 && n < 400)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 400)
         check(8'h00, 8'h01);
      else
      begin
         cmd(8'h36, 1'b0, 8'h00, 1'b1, s);
         cmd(8'h36, 1'b1, 8'h53, 1'b1, 8'h53);
      end
   endtask

   initial
   begin
      error_cnt = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      cmdValid = 1'b0;
      cmdByte = 8'h00;
      keyInfo = '0;
      statFlags = '0;
      acqStep = 1'b0;
      do_reset();
      cmd(8'h53, 1'b0, 8'h00, 1'b1, 8'h53);
      t_scope();
      t_status();
      t_acq();
      t_checksum();
      do_reset();
      t_checksum();
      test_done();
   end
endmodule
